// >>> io_far_side_model.sv
/*
 Far-side model: external pins and internal function modules feeding the
 switch matrix, driven from one flat source vector indexed like the matrix.
 Assumes the bench changes the vector just after a rising ref_clk edge.
*/
module io_far_side_model
   import io_switch_pkg::*;
(
   input wire logic ref_clk,
   input wire logic [SRC_COUNT-1:0] src_v,
   output pin_in_t pins,
   output module_out_t mods
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      pins = '0;
      mods = '0;
   end
   // Place each source index on its pin or module output
   always @(posedge ref_clk) begin
      pins.ext_in <= src_v[3:0];
      pins.serial_rx <= src_v[4];
      mods.uart1_tx <= src_v[5];
      mods.strobe <= {src_v[21], src_v[20], src_v[7], src_v[6]};
      mods.pwm <= {src_v[14], src_v[13], src_v[9], src_v[8]};
      pins.expose <= src_v[10];
      pins.readout <= src_v[11];
      mods.seq_pulse <= src_v[12];
      mods.seq_active <= src_v[15];
      mods.debounce <= src_v[16];
      mods.prescale <= src_v[17];
      mods.seq_mask <= src_v[18];
      mods.logic_result <= src_v[19];
      pins.lens_rx <= src_v[22];
      pins.trig_feedback <= src_v[23];
      mods.uart2_tx <= src_v[24];
   end
endmodule

// >>> io_line_stage.sv
/*
 One destination line: registered source select, inversion, force high.
 Assumes the source vector is already synchronous to ref_clk.
*/
module io_line_stage
   import io_switch_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [SRC_COUNT-1:0] src_vec,
   input wire line_cfg_t cfg,
   output logic line_out
);
   typedef struct packed {
      logic out;
   } stage_state_t;
   stage_state_t state, next_state;
   logic picked;
   always_comb begin
      next_state = state;
      picked = 1'b0;
      if (cfg.src < SRC_W'(SRC_COUNT)) begin
         picked = src_vec[cfg.src];
      end
      if (cfg.force_high) begin
         picked = 1'b1;
      end
      next_state.out = picked ^ cfg.invert;
   end
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end
   assign line_out = state.out;
   a_line_force: assert property (@(posedge ref_clk) disable iff (!rst_b)
      cfg.force_high |=> line_out == !$past(cfg.invert)) else $error("force level wrong");
   a_line_idle: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (cfg.src >= SRC_W'(SRC_COUNT) && !cfg.force_high) |=> line_out == $past(cfg.invert))
      else $error("unused line not low");
endmodule

// >>> io_switch_matrix.sv
/*
 Switch matrix that routes 25 sources to 23 destination lines, with
 per-line inversion and force high, and eight stored configuration sets.
 Assumes pins arrive asynchronously and module outputs are on ref_clk.
 Registers are reached over a plain strobe port with one-cycle read data.
*/
// Contract
// - Any source routes to any destination line
// - Destination lines indexed zero through twenty-two
// - Store routing on request, restore defaults internally
// - Sources zero to three are trigger pins
// - Sources 6,7,20,21 carry pulse-loop strobes
// - Sequencer PWM, pulse, mask, active on sources
// - Debounce, prescale, logic results on 16,17,19
// - Serial receive, lens receive, UARTs, feedback sources
// - Durations count in fifteen nanosecond steps
// - Configuration writes take effect immediately
// - Eight stored sets, recall, stored set boot_set (zero after reset) loaded at start
// - Each line may be inverted
// - Force high, or low when inverted
module io_switch_matrix
   import io_switch_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire bus_req_t bus,
   output logic [31:0] rdata,
   input wire pin_in_t pins,
   input wire module_out_t mods,
   output logic [DST_COUNT-1:0] dest_line,
   output logic store_busy
);
   typedef enum logic [1:0] {ST_BOOT, ST_RUN} mode_t;
   typedef struct packed {
      pin_in_t sync1;
      pin_in_t sync2;
      line_cfg_t [DST_COUNT-1:0] live;
      logic [SET_W-1:0] set_index;
      logic [SET_W-1:0] boot_set;
      logic [31:0] rdata;
      logic busy;
      mode_t mode;
   } matrix_state_t;
   matrix_state_t state, next_state;
   logic [SRC_COUNT-1:0] src_vec;
   logic [DST_COUNT-1:0] line_q;
   logic [DST_W-1:0] line_idx;
   logic line_hit;
   line_cfg_t [SET_COUNT-1:0][DST_COUNT-1:0] nv_sets, next_nv_sets;
   line_cfg_t wr_cfg;
   logic [31:0] line_word;
   always_comb begin
      src_vec = '0;
      src_vec[3:0] = state.sync2.ext_in;
      src_vec[SRC_SERIAL_RX] = state.sync2.serial_rx;
      src_vec[SRC_UART1_TX] = mods.uart1_tx;
      src_vec[SRC_STROBE0] = mods.strobe[0];
      src_vec[SRC_STROBE1] = mods.strobe[1];
      src_vec[SRC_PWM_A] = mods.pwm[0];
      src_vec[SRC_PWM_B] = mods.pwm[1];
      src_vec[SRC_EXPOSE] = state.sync2.expose;
      src_vec[SRC_READOUT] = state.sync2.readout;
      src_vec[SRC_SEQ_PULSE] = mods.seq_pulse;
      src_vec[SRC_PWM_C] = mods.pwm[2];
      src_vec[SRC_PWM_D] = mods.pwm[3];
      src_vec[SRC_SEQ_ACTIVE] = mods.seq_active;
      src_vec[SRC_DEBOUNCE] = mods.debounce;
      src_vec[SRC_PRESCALE] = mods.prescale;
      src_vec[SRC_SEQ_MASK] = mods.seq_mask;
      src_vec[SRC_LOGIC] = mods.logic_result;
      src_vec[SRC_STROBE2] = mods.strobe[2];
      src_vec[SRC_STROBE3] = mods.strobe[3];
      src_vec[SRC_LENS_RX] = state.sync2.lens_rx;
      src_vec[SRC_TRIG_FB] = state.sync2.trig_feedback;
      src_vec[SRC_UART2_TX] = mods.uart2_tx;
   end
   // One stage per destination line
   generate
      for (genvar d = 0; d < DST_COUNT; d++) begin : g_line
         io_line_stage u_stage (
            .ref_clk(ref_clk),
            .rst_b(rst_b),
            .src_vec(src_vec),
            .cfg(state.live[d]),
            .line_out(line_q[d])
         );
      end
   endgenerate
   assign line_idx = bus.addr[DST_W+1:2];
   assign line_hit = (bus.addr[7:DST_W+2] == 1'b0) && (line_idx < DST_W'(DST_COUNT));
   assign wr_cfg = '{force_high: bus.wdata[LINE_FORCE_BIT], invert: bus.wdata[LINE_INV_BIT],
      src: bus.wdata[LINE_SRC_LSB +: SRC_W]};
   // Line register word: source, inversion and force at their fields
   always_comb begin
      line_word = '0;
      line_word[LINE_SRC_LSB +: SRC_W] = state.live[line_idx].src;
      line_word[LINE_INV_BIT] = state.live[line_idx].invert;
      line_word[LINE_FORCE_BIT] = state.live[line_idx].force_high;
   end
   always_comb begin
      next_state = state;
      next_state.sync1 = pins;
      next_state.sync2 = state.sync1;
      next_state.rdata = '0;
      next_state.busy = 1'b0;
      next_nv_sets = nv_sets;
      case (state.mode)
         ST_BOOT: begin
            next_state.live = nv_sets[state.boot_set];
            next_state.mode = ST_RUN;
         end
         ST_RUN: begin
            if (bus.wr) begin
               if (line_hit) begin
                  next_state.live[line_idx] = wr_cfg;
               end else if (bus.addr == ADDR_CTRL) begin
                  next_state.set_index = bus.wdata[CTRL_SET_LSB +: SET_W];
                  next_state.boot_set = bus.wdata[CTRL_BOOT_LSB +: SET_W];
                  if (bus.wdata[CTRL_STORE_BIT]) begin
                     next_nv_sets[bus.wdata[CTRL_SET_LSB +: SET_W]] = state.live;
                     next_state.busy = 1'b1;
                  end else if (bus.wdata[CTRL_RECALL_BIT]) begin
                     next_state.live = nv_sets[bus.wdata[CTRL_SET_LSB +: SET_W]];
                  end else if (bus.wdata[CTRL_DEFAULT_BIT]) begin
                     next_state.live = {DST_COUNT{LINE_RESET}};
                  end
               end
            end
            if (bus.rd) begin
               if (line_hit) begin
                  next_state.rdata = line_word;
               end else if (bus.addr == ADDR_CTRL) begin
                  next_state.rdata[CTRL_SET_LSB +: SET_W] = state.set_index;
                  next_state.rdata[CTRL_BOOT_LSB +: SET_W] = state.boot_set;
               end else if (bus.addr == ADDR_STATUS) begin
                  next_state.rdata = 32'(line_q);
               end else if (bus.addr == ADDR_STEP_NS) begin
                  next_state.rdata = 32'(SYS_STEP_NS);
               end
            end
         end
         default: begin
            next_state.mode = ST_BOOT;
         end
      endcase
   end
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state.sync1 <= '0;
         state.sync2 <= '0;
         state.live <= {DST_COUNT{LINE_RESET}};
         state.set_index <= '0;
         state.boot_set <= BOOT_SET_RESET;
         state.rdata <= '0;
         state.busy <= 1'b0;
         state.mode <= ST_BOOT;
      end else begin
         state.sync1 <= next_state.sync1;
         state.sync2 <= next_state.sync2;
         state.live <= next_state.live;
         state.set_index <= next_state.set_index;
         state.boot_set <= next_state.boot_set;
         state.rdata <= next_state.rdata;
         state.busy <= next_state.busy;
         state.mode <= next_state.mode;
      end
   end
   // Stored sets survive the block reset, as nonvolatile contents would
   always_ff @(posedge ref_clk) begin
      nv_sets <= next_nv_sets;
   end
   assign rdata = state.rdata;
   assign dest_line = line_q;
   assign store_busy = state.busy;
   // Command sequences, recognised only in run mode
   sequence s_line_write;
      bus.wr && line_hit && state.mode == ST_RUN;
   endsequence
   sequence s_ctrl_write;
      bus.wr && bus.addr == ADDR_CTRL && state.mode == ST_RUN;
   endsequence
   sequence s_store_cmd;
      s_ctrl_write ##0 bus.wdata[CTRL_STORE_BIT];
   endsequence
   sequence s_recall_cmd;
      s_ctrl_write ##0 (!bus.wdata[CTRL_STORE_BIT] && bus.wdata[CTRL_RECALL_BIT]);
   endsequence
   sequence s_default_cmd;
      s_ctrl_write ##0 (!bus.wdata[CTRL_STORE_BIT] && !bus.wdata[CTRL_RECALL_BIT] && bus.wdata[CTRL_DEFAULT_BIT]);
   endsequence
   sequence s_line_read;
      bus.rd && line_hit && state.mode == ST_RUN;
   endsequence
   // Line d holds source s with neither inversion nor force
   sequence s_plain(int d, logic [SRC_W-1:0] s);
      state.live[d].src == s && !state.live[d].force_high && !state.live[d].invert;
   endsequence
   a_write_live: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_line_write |=> state.live[$past(line_idx)].src == $past(bus.wdata[LINE_SRC_LSB +: SRC_W])
      && state.live[$past(line_idx)].invert == $past(bus.wdata[LINE_INV_BIT])
      && state.live[$past(line_idx)].force_high == $past(bus.wdata[LINE_FORCE_BIT]))
      else $error("line write not applied");
   a_read_step: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (bus.rd && bus.addr == ADDR_STEP_NS && state.mode == ST_RUN) |=> rdata == 32'(SYS_STEP_NS))
      else $error("step read wrong");
   a_store_pulse: assert property (@(posedge ref_clk) disable iff (!rst_b)
      store_busy |-> $past(bus.wr) && $past(bus.addr) == ADDR_CTRL && $past(bus.wdata[CTRL_STORE_BIT]))
      else $error("stray store flag");
   a_store_busy: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_store_cmd |=> store_busy)
      else $error("store flag missing");
   a_busy_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (!bus.wr || bus.addr != ADDR_CTRL || !bus.wdata[CTRL_STORE_BIT])
      |=> !store_busy)
      else $error("store flag without store");
   a_store_copy: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_store_cmd |=> nv_sets[$past(bus.wdata[CTRL_SET_LSB +: SET_W])] == $past(state.live))
      else $error("store did not copy routing");
   a_recall_load: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_recall_cmd |=> state.live == $past(nv_sets[bus.wdata[CTRL_SET_LSB +: SET_W]]))
      else $error("recall did not load set");
   a_default_load: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_default_cmd |=> state.live == {DST_COUNT{LINE_RESET}})
      else $error("default routing not restored");
   a_ctrl_fields: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_ctrl_write |=> state.set_index == $past(bus.wdata[CTRL_SET_LSB +: SET_W])
      && state.boot_set == $past(bus.wdata[CTRL_BOOT_LSB +: SET_W]))
      else $error("control fields not written");
   a_ctrl_read: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (bus.rd && bus.addr == ADDR_CTRL && state.mode == ST_RUN) |=> rdata[CTRL_SET_LSB +: SET_W] == $past(state.set_index)
      && rdata[CTRL_BOOT_LSB +: SET_W] == $past(state.boot_set))
      else $error("control read wrong");
   a_boot_once: assert property (@(posedge ref_clk) disable iff (!rst_b)
      state.mode == ST_BOOT |=> state.mode == ST_RUN)
      else $error("boot stuck");
   a_boot_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (state.mode == ST_BOOT && bus.wr) |=> !store_busy)
      else $error("write taken during boot");
   a_unmapped_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (bus.wr && !line_hit && bus.addr != ADDR_CTRL && state.mode == ST_RUN)
      |=> state.live == $past(state.live))
      else $error("unmapped write changed routing");
   a_unmapped_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (bus.rd && !line_hit && bus.addr != ADDR_CTRL && bus.addr != ADDR_STATUS && bus.addr != ADDR_STEP_NS)
      |=> rdata == '0)
      else $error("unmapped read nonzero");
   a_read_line: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_line_read |=> rdata[LINE_SRC_LSB +: SRC_W] == $past(state.live[line_idx].src)
      && rdata[LINE_INV_BIT] == $past(state.live[line_idx].invert)
      && rdata[LINE_FORCE_BIT] == $past(state.live[line_idx].force_high))
      else $error("line read wrong");
   a_read_status: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (bus.rd && bus.addr == ADDR_STATUS && state.mode == ST_RUN) |=> rdata == 32'($past(dest_line)))
      else $error("status read wrong");
   a_rdata_stand: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !bus.rd |=> rdata == '0)
      else $error("read data held too long");
   a_idle_low: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (state.live[1] == LINE_RESET) [*2] |-> !dest_line[1])
      else $error("idle line high");
   a_line3_invert: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (state.live[3].src == 5'h03 && state.live[3].invert && !state.live[3].force_high)
      |=> dest_line[3] == !$past(state.sync2.ext_in[3]))
      else $error("inverted line wrong");
   a_line3_force: assert property (@(posedge ref_clk) disable iff (!rst_b)
      state.live[3].force_high |=> dest_line[3] == !$past(state.live[3].invert))
      else $error("forced line wrong");
   a_line3_range: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (state.live[3].src >= SRC_W'(SRC_COUNT) && !state.live[3].force_high)
      |=> dest_line[3] == $past(state.live[3].invert))
      else $error("unused source not low");
   // Every source routed plainly reaches its line one cycle on
   a_pin_route: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_plain(0, SRC_EXT_IN0) |=> dest_line[0] == $past(state.sync2.ext_in[0]))
      else $error("pin route wrong");
   a_route_pin1: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_plain(1, 5'h01) |=> dest_line[1] == $past(state.sync2.ext_in[1]))
      else $error("pin 1 route wrong");
   a_route_pin2: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_plain(2, 5'h02) |=> dest_line[2] == $past(state.sync2.ext_in[2]))
      else $error("pin 2 route wrong");
   a_route_pin3: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_plain(3, 5'h03) |=> dest_line[3] == $past(state.sync2.ext_in[3]))
      else $error("pin 3 route wrong");
   a_route_serial: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_plain(4, SRC_SERIAL_RX) |=> dest_line[4] == $past(state.sync2.serial_rx))
      else $error("serial receive route wrong");
   a_route_uart1: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_plain(5, SRC_UART1_TX) |=> dest_line[5] == $past(mods.uart1_tx))
      else $error("first uart route wrong");
   a_route_strobe0: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_plain(6, SRC_STROBE0) |=> dest_line[6] == $past(mods.strobe[0]))
      else $error("strobe 0 route wrong");
   a_route_strobe1: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_plain(7, SRC_STROBE1) |=> dest_line[7] == $past(mods.strobe[1]))
      else $error("strobe 1 route wrong");
   a_route_pwm_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_plain(8, SRC_PWM_A) |=> dest_line[8] == $past(mods.pwm[0]))
      else $error("pwm a route wrong");
   a_route_pwm_b: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_plain(9, SRC_PWM_B) |=> dest_line[9] == $past(mods.pwm[1]))
      else $error("pwm b route wrong");
   a_route_expose: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_plain(10, SRC_EXPOSE) |=> dest_line[10] == $past(state.sync2.expose))
      else $error("expose route wrong");
   a_route_readout: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_plain(11, SRC_READOUT) |=> dest_line[11] == $past(state.sync2.readout))
      else $error("readout route wrong");
   a_route_seq_pulse: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_plain(12, SRC_SEQ_PULSE) |=> dest_line[12] == $past(mods.seq_pulse))
      else $error("sequencer pulse route wrong");
   a_route_pwm_c: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_plain(13, SRC_PWM_C) |=> dest_line[13] == $past(mods.pwm[2]))
      else $error("pwm c route wrong");
   a_route_pwm_d: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_plain(14, SRC_PWM_D) |=> dest_line[14] == $past(mods.pwm[3]))
      else $error("pwm d route wrong");
   a_route_active: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_plain(15, SRC_SEQ_ACTIVE) |=> dest_line[15] == $past(mods.seq_active))
      else $error("sequencer active route wrong");
   a_route_prescale: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_plain(17, SRC_PRESCALE) |=> dest_line[17] == $past(mods.prescale))
      else $error("prescaler route wrong");
   a_route_mask: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_plain(18, SRC_SEQ_MASK) |=> dest_line[18] == $past(mods.seq_mask))
      else $error("mask pulse route wrong");
   a_route_logic: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_plain(19, SRC_LOGIC) |=> dest_line[19] == $past(mods.logic_result))
      else $error("logic result route wrong");
   a_route_strobe2: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_plain(20, SRC_STROBE2) |=> dest_line[20] == $past(mods.strobe[2]))
      else $error("strobe 2 route wrong");
   a_route_strobe3: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_plain(21, SRC_STROBE3) |=> dest_line[21] == $past(mods.strobe[3]))
      else $error("strobe 3 route wrong");
   a_route_lens: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_plain(22, SRC_LENS_RX) |=> dest_line[22] == $past(state.sync2.lens_rx))
      else $error("lens receive route wrong");
   a_route_feedback: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_plain(0, SRC_TRIG_FB) |=> dest_line[0] == $past(state.sync2.trig_feedback))
      else $error("trigger feedback route wrong");
   a_route_uart2: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_plain(1, SRC_UART2_TX) |=> dest_line[1] == $past(mods.uart2_tx))
      else $error("second uart route wrong");
   a_debounce_route: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (state.live[16].src == SRC_DEBOUNCE && !state.live[16].force_high)
      |=> dest_line[16] == ($past(mods.debounce) ^ $past(state.live[16].invert)))
      else $error("debounce route");
endmodule

// >>> io_switch_pkg.sv
/*
 Shared constants and types for the I/O switch matrix: source and
 destination counts, register map, line field layout, store slots.
 Assumes a single 10 MHz ref_clk domain.
*/
package io_switch_pkg;
   localparam int SRC_COUNT = 25;
   localparam int DST_COUNT = 23;
   localparam int SRC_W = 5;
   localparam int DST_W = 5;
   localparam int SET_COUNT = 8;
   localparam int SET_W = 3;
   localparam logic [SRC_W-1:0] SRC_IDLE = 5'h1F;
   localparam logic [4:0] SRC_EXT_IN0 = 5'h00;
   localparam logic [4:0] SRC_SERIAL_RX = 5'h04;
   localparam logic [4:0] SRC_UART1_TX = 5'h05;
   localparam logic [4:0] SRC_STROBE0 = 5'h06;
   localparam logic [4:0] SRC_STROBE1 = 5'h07;
   localparam logic [4:0] SRC_PWM_A = 5'h08;
   localparam logic [4:0] SRC_PWM_B = 5'h09;
   localparam logic [4:0] SRC_EXPOSE = 5'h0A;
   localparam logic [4:0] SRC_READOUT = 5'h0B;
   localparam logic [4:0] SRC_SEQ_PULSE = 5'h0C;
   localparam logic [4:0] SRC_PWM_C = 5'h0D;
   localparam logic [4:0] SRC_PWM_D = 5'h0E;
   localparam logic [4:0] SRC_SEQ_ACTIVE = 5'h0F;
   localparam logic [4:0] SRC_DEBOUNCE = 5'h10;
   localparam logic [4:0] SRC_PRESCALE = 5'h11;
   localparam logic [4:0] SRC_SEQ_MASK = 5'h12;
   localparam logic [4:0] SRC_LOGIC = 5'h13;
   localparam logic [4:0] SRC_STROBE2 = 5'h14;
   localparam logic [4:0] SRC_STROBE3 = 5'h15;
   localparam logic [4:0] SRC_LENS_RX = 5'h16;
   localparam logic [4:0] SRC_TRIG_FB = 5'h17;
   localparam logic [4:0] SRC_UART2_TX = 5'h18;
   // Register map, byte addresses
   localparam logic [7:0] ADDR_LINE_BASE = 8'h00;
   localparam logic [7:0] ADDR_CTRL = 8'h60;
   localparam logic [7:0] ADDR_STATUS = 8'h64;
   localparam logic [7:0] ADDR_STEP_NS = 8'h68;
   // Line register fields
   localparam int LINE_SRC_LSB = 0;
   localparam int LINE_INV_BIT = 8;
   localparam int LINE_FORCE_BIT = 9;
   // Control register fields
   localparam int CTRL_SET_LSB = 0;
   localparam int CTRL_STORE_BIT = 4;
   localparam int CTRL_RECALL_BIT = 5;
   localparam int CTRL_DEFAULT_BIT = 6;
   localparam int CTRL_BOOT_LSB = 8;
   localparam logic [SET_W-1:0] BOOT_SET_RESET = 3'h0;
   // Timing
   localparam int SYS_STEP_NS = 15;
   localparam real SYS_CLK_MHZ = 66.6;
   localparam real REF_CLK_MHZ = 10.0;
   typedef struct packed {
      logic force_high;
      logic invert;
      logic [SRC_W-1:0] src;
   } line_cfg_t;
   localparam line_cfg_t LINE_RESET = '{force_high: 1'b0, invert: 1'b0, src: SRC_IDLE};
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;
   typedef struct packed {
      logic [3:0] ext_in;
      logic serial_rx;
      logic lens_rx;
      logic trig_feedback;
      logic expose;
      logic readout;
   } pin_in_t;
   typedef struct packed {
      logic uart1_tx;
      logic uart2_tx;
      logic [3:0] strobe;
      logic [3:0] pwm;
      logic seq_pulse;
      logic seq_mask;
      logic seq_active;
      logic debounce;
      logic prescale;
      logic logic_result;
   } module_out_t;
endpackage

// >>> test_io_switch_matrix.sv
/*
 Self-checking bench for the switch matrix: routing, inversion, force,
 stored sets and boot recall, through the register port.
 Assumes one 10 MHz clock and the far-side model beside the design.
*/
module test_io_switch_matrix
   import io_switch_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   bus_req_t bus = '0;
   logic [31:0] rdata;
   logic [SRC_COUNT-1:0] src_v = '0;
   pin_in_t pins;
   module_out_t mods;
   logic [DST_COUNT-1:0] dest_line;
   logic store_busy;
   logic [31:0] q;
   logic [31:0] cfgs [6] = '{32'h003, 32'h103, 32'h203, 32'h303, 32'h019, 32'h119};
   logic [5:0] exps = 6'h25;
   int failures = 0;
   int cmp_count = 0;
   always #50 ref_clk = ~ref_clk;
   io_far_side_model far (.ref_clk(ref_clk), .src_v(src_v), .pins(pins), .mods(mods));
   io_switch_matrix dut (.ref_clk(ref_clk), .rst_b(rst_b), .bus(bus), .rdata(rdata), .pins(pins),
      .mods(mods), .dest_line(dest_line), .store_busy(store_busy));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge ref_clk);
      bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge ref_clk);
      bus.rd <= 1'b0;
      @(negedge ref_clk);
      q = rdata;
   endtask
   function automatic logic [7:0] la(input int n);
      return ADDR_LINE_BASE + 8'(4 * n);
   endfunction
   task automatic settle();
      repeat (6) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   task automatic results();
      $display("Comparisons %0d, failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      #3ms;
      failures++;
      results();
   end
   initial begin
      repeat (6) @(posedge ref_clk);
      chk(32'(dest_line), 32'h0);
      rst_b <= 1'b1;
      repeat (2) @(posedge ref_clk);
      // Default routing, then line registers and constants
      wr(ADDR_CTRL, 32'h40);
      for (int n = 0; n < DST_COUNT; n++) begin
         rd(la(n));
         chk(q, 32'h1F);
      end
      rd(ADDR_STEP_NS);
      chk(q, 32'h0F);
      wr(8'h6C, 32'hFFFFFFFF);
      rd(8'h6C);
      chk(q, 32'h0);
      // Every source to a line, one source high at a time
      for (int s = 0; s < SRC_COUNT; s++) begin
         wr(la(s % DST_COUNT), 32'(s));
         src_v <= 25'h1 << s;
         settle();
         chk(32'(dest_line), 32'h1 << (s % DST_COUNT));
         rd(ADDR_STATUS);
         chk(q, 32'h1 << (s % DST_COUNT));
      end
      // Inversion, force and out-of-range source on line 3, seen two cycles on
      src_v <= '1;
      settle();
      for (int i = 0; i < 6; i++) begin
         wr(la(3), cfgs[i]);
         @(posedge ref_clk);
         @(negedge ref_clk);
         chk(32'(dest_line[3]), 32'(exps[i]));
      end
      // Store, default, recall
      wr(la(5), 32'h13);
      wr(ADDR_CTRL, 32'h13);
      @(negedge ref_clk);
      chk(32'(store_busy), 32'h1);
      @(negedge ref_clk);
      chk(32'(store_busy), 32'h0);
      wr(la(5), 32'h0C);
      wr(ADDR_CTRL, 32'h17);
      wr(ADDR_CTRL, 32'h40);
      rd(la(5));
      chk(q, 32'h1F);
      wr(ADDR_CTRL, 32'h23);
      rd(la(5));
      chk(q, 32'h13);
      wr(ADDR_CTRL, 32'h27);
      rd(la(5));
      chk(q, 32'h0C);
      wr(ADDR_CTRL, 32'h503);
      rd(ADDR_CTRL);
      chk(q, 32'h503);
      // Set zero loads at start-up
      wr(ADDR_CTRL, 32'h10);
      wr(la(5), 32'h1F);
      rst_b <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk(32'(dest_line), 32'h0);
      rst_b <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rd(la(5));
      chk(q, 32'h0C);
      results();
   end
endmodule
